// file: rtl/ecs_pkg.sv
// Shared constants and types for the engine controller status register bank.
// Assumes one system clock; register numbers are the holding register numbers seen by the serial master.
package ecs_pkg;

    // Holding register numbers
    localparam logic [15:0] REG_HOURS_HI = 16'h9c41;
    localparam logic [15:0] REG_HOURS_LO = 16'h9c42;
    localparam logic [15:0] REG_SPEED = 16'h9c43;
    localparam logic [15:0] REG_VOLTAGE = 16'h9c44;
    localparam logic [15:0] REG_OIL = 16'h9c45;
    localparam logic [15:0] REG_TEMP = 16'h9c46;
    localparam logic [15:0] REG_STATE = 16'h9c47;
    localparam logic [15:0] REG_FLAGS_A = 16'h9c48;
    localparam logic [15:0] REG_FLAGS_B = 16'h9c49;
    localparam logic [15:0] REG_FLAGS_C = 16'h9c4a;
    localparam logic [15:0] REG_LEVEL = 16'h9c4b;
    localparam logic [15:0] REG_RUN_CMD = 16'h9c4c;
    localparam logic [15:0] REG_SPEED_CEIL = 16'h9c4d;
    localparam logic [15:0] REG_AMBIENT = 16'h9c4e;
    localparam logic [15:0] REG_MODE = 16'h9c4f;
    localparam logic [15:0] REG_LOADED_SPEED = 16'h9c50;
    localparam logic [15:0] REG_MANUAL_ONLY = 16'h9c51;

    // Node address the bank answers to by default
    localparam logic [7:0] NODE_DEFAULT = 8'h01;

    // Field layout
    localparam int FLAGS_C_USED = 2;
    localparam logic RUN_STOP = 1'b0;
    localparam logic RUN_START = 1'b1;
    localparam logic MODE_MANUAL = 1'b0;
    localparam logic MODE_AUTO = 1'b1;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // Sequencer state codes
    typedef enum logic [4:0] {
        SEQ_STABILIZE = 5'b00000,
        SEQ_STOPPED = 5'b00001,
        SEQ_STANDBY = 5'b00010,
        SEQ_PRESTART1 = 5'b00011,
        SEQ_SAFE_CHECK = 5'b00100,
        SEQ_PRESTART2 = 5'b00101,
        SEQ_CRANK_ON = 5'b00110,
        SEQ_CRANK_REST = 5'b00111,
        SEQ_FALSE_START = 5'b01000,
        SEQ_WARMUP = 5'b01001,
        SEQ_LINE_FILL1 = 5'b01010,
        SEQ_LINE_FILL2 = 5'b01011,
        SEQ_RUN_LOADED = 5'b01100,
        SEQ_COOLDOWN = 5'b01101,
        SEQ_ENERGIZE_STOP = 5'b01110,
        SEQ_SPINDOWN = 5'b01111,
        SEQ_WAIT_START = 5'b10000
    } ecs_seq_t;

    // One register access from the link framer
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] node;
        logic [15:0] addr;
        logic [15:0] data;
    } ecs_req_t;

    // Live engine measurements and status
    typedef struct packed {
        logic [31:0] hours;
        logic [15:0] speed;
        logic [15:0] voltTenths;
        logic [15:0] oil;
        logic [15:0] temp;
        logic [15:0] level;
        logic [15:0] ambient;
        logic [15:0] loadedSpeed;
        logic manualOnly;
        ecs_seq_t seqState;
        logic [15:0] shutdownCauseA;
        logic [15:0] shutdownCauseB;
        logic [1:0] shutdownCauseC;
    } ecs_meas_t;

    // Writable control settings
    typedef struct packed {
        logic runStart;
        logic modeAuto;
        logic [15:0] speedCeil;
    } ecs_ctrl_t;

endpackage : ecs_pkg

// file: rtl/ecs_regs.sv
// Holding register bank of the engine controller: status words and remote override controls.
// Assumes a framer on the same clock hands over one decoded access per valid cycle,
// and that the settings store outside supplies the restored settings during reset.
//
// Contract
// - Remote writes land only in read-and-write registers and act as temporary overrides of local settings.
// - After power-up the overrides return to the stored local settings unless a save committed them.
// - Run hours read as one 32-bit value over two consecutive read-only registers.
// - Supply voltage reads as an integer in tenths of a volt.
// - The sequencer state reads as a code from 0 to 16.
// - Shutdown causes read as flags in three read-only words, 1 while active and 0 while inactive.
// - The first shutdown word carries sixteen engine and fuel shutdown causes on bits 0 to 15.
// - The second shutdown word carries fifteen causes on bits 0 to 14 and the red lamp on bit 15.
// - The third shutdown word uses bits 0 and 1 and holds bits 2 to 15 reserved.
// - The start/stop register takes 1 for start and 0 for stop, is acted on and reads back.
// - The mode register takes 0 for manual and 1 for automatic and the device adopts it.
// - A read-only flag reads 1 while manual-only operation is enabled.
// - A read-only register reports the running loaded speed for automatic operation.
// - Only accesses carrying the configured node number are answered, default node 1.
`timescale 1ns/1ps
module ecs_regs #(
    parameter logic [7:0] NODE_ADDR = ecs_pkg::NODE_DEFAULT
) (
    input wire logic clk, // System clock, 10 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clkEn, // Clock enable, freezes all state when low
    input wire ecs_pkg::ecs_req_t req, // Decoded register access from the framer
    input wire ecs_pkg::ecs_meas_t meas, // Live engine measurements
    input wire ecs_pkg::ecs_ctrl_t localCtrl, // Settings restored at power-up or entered locally
    input wire logic localLoad, // Pulse: operator entered new local settings
    input wire logic saveReq, // Pulse: master committed overrides
    output logic rspValid_q, // Pulse: answer ready
    output logic [15:0] rspData_q, // Read data or echoed write data
    output logic rspFault_q, // Answer is an illegal address exception
    output ecs_pkg::ecs_ctrl_t ctrl_q, // Settings in force
    output logic saveStrobe_q, // Pulse: store ctrl_q as local settings
    output ecs_pkg::ecs_ctrl_t savedCtrl_q // Settings to store on save
);

    ecs_pkg::ecs_meas_t snap_q;
    logic forUs;
    logic isRw;
    logic mapped;
    logic [15:0] readWord;

    // Snapshot of live status, refreshed every enabled cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            snap_q <= '0;
        end else if (clkEn) begin
            snap_q <= meas;
        end
    end

    // Address filter
    assign forUs = req.valid && (req.node == NODE_ADDR);

    // Register decode and read multiplexer
    always_comb begin
        readWord = ecs_pkg::WORD_ZERO;
        mapped = 1'b1;
        isRw = 1'b0;
        case (req.addr)
            ecs_pkg::REG_HOURS_HI: begin
                readWord = snap_q.hours[31:16];
            end
            ecs_pkg::REG_HOURS_LO: begin
                readWord = snap_q.hours[15:0];
            end
            ecs_pkg::REG_SPEED: begin
                readWord = snap_q.speed;
            end
            ecs_pkg::REG_VOLTAGE: begin
                readWord = snap_q.voltTenths;
            end
            ecs_pkg::REG_OIL: begin
                readWord = snap_q.oil;
            end
            ecs_pkg::REG_TEMP: begin
                readWord = snap_q.temp;
            end
            ecs_pkg::REG_STATE: begin
                readWord = {11'h000, snap_q.seqState};
            end
            ecs_pkg::REG_FLAGS_A: begin
                readWord = snap_q.shutdownCauseA;
            end
            ecs_pkg::REG_FLAGS_B: begin
                readWord = snap_q.shutdownCauseB;
            end
            ecs_pkg::REG_FLAGS_C: begin
                readWord = {14'h0000, snap_q.shutdownCauseC};
            end
            ecs_pkg::REG_LEVEL: begin
                readWord = snap_q.level;
            end
            ecs_pkg::REG_RUN_CMD: begin
                readWord = {15'h0000, ctrl_q.runStart};
                isRw = 1'b1;
            end
            ecs_pkg::REG_SPEED_CEIL: begin
                readWord = ctrl_q.speedCeil;
                isRw = 1'b1;
            end
            ecs_pkg::REG_AMBIENT: begin
                readWord = snap_q.ambient;
            end
            ecs_pkg::REG_MODE: begin
                readWord = {15'h0000, ctrl_q.modeAuto};
                isRw = 1'b1;
            end
            ecs_pkg::REG_LOADED_SPEED: begin
                readWord = snap_q.loadedSpeed;
            end
            ecs_pkg::REG_MANUAL_ONLY: begin
                readWord = {15'h0000, snap_q.manualOnly};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Settings in force: restored at reset, overridden by remote writes, reloaded by local entry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= localCtrl;
        end else if (clkEn) begin
            if (forUs && req.write && isRw) begin
                case (req.addr)
                    ecs_pkg::REG_RUN_CMD: begin
                        ctrl_q.runStart <= req.data[0];
                    end
                    ecs_pkg::REG_MODE: begin
                        ctrl_q.modeAuto <= req.data[0];
                    end
                    default: begin
                        ctrl_q.speedCeil <= req.data;
                    end
                endcase
            end else if (localLoad) begin
                ctrl_q <= localCtrl;
            end
        end
    end

    // Save commit hands the overrides to the settings store
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            saveStrobe_q <= 1'b0;
            savedCtrl_q <= '0;
        end else if (clkEn) begin
            saveStrobe_q <= saveReq;
            if (saveReq) begin
                savedCtrl_q <= ctrl_q;
            end
        end
    end

    // Answer to each access addressed to this node
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rspValid_q <= 1'b0;
            rspData_q <= ecs_pkg::WORD_ZERO;
            rspFault_q <= 1'b0;
        end else if (clkEn) begin
            rspValid_q <= forUs;
            if (forUs) begin
                if (!mapped || (req.write && !isRw)) begin
                    rspFault_q <= 1'b1;
                    rspData_q <= ecs_pkg::WORD_ZERO;
                end else begin
                    rspFault_q <= 1'b0;
                    rspData_q <= req.write ? req.data : readWord;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_restore;
        disable iff (1'b0)
        $rose(rst_n) |-> ctrl_q == $past(localCtrl);
    endproperty
    a_restore: assert property (p_restore) else $error("settings not restored at reset");

    property p_runWrite;
        clkEn && forUs && req.write && req.addr == ecs_pkg::REG_RUN_CMD
            |=> ctrl_q.runStart == $past(req.data[0]) && rspValid_q && !rspFault_q;
    endproperty
    a_runWrite: assert property (p_runWrite) else $error("start/stop write not taken");

    property p_modeWrite;
        clkEn && forUs && req.write && req.addr == ecs_pkg::REG_MODE
            |=> ctrl_q.modeAuto == $past(req.data[0]);
    endproperty
    a_modeWrite: assert property (p_modeWrite) else $error("mode write not adopted");

    property p_ceilWrite;
        clkEn && forUs && req.write && req.addr == ecs_pkg::REG_SPEED_CEIL |=> ctrl_q.speedCeil == $past(req.data);
    endproperty
    a_ceilWrite: assert property (p_ceilWrite) else $error("speed ceiling write not taken");

    property p_roWrite;
        clkEn && forUs && req.write && mapped && !isRw && !localLoad |=> rspFault_q && $stable(ctrl_q);
    endproperty
    a_roWrite: assert property (p_roWrite) else $error("read-only write not refused");

    property p_otherNode;
        clkEn && req.valid && req.node != NODE_ADDR |=> !rspValid_q;
    endproperty
    a_otherNode: assert property (p_otherNode) else $error("answered foreign node");

    property p_hoursHi;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_HOURS_HI
            |=> rspData_q == $past(snap_q.hours[31:16]);
    endproperty
    a_hoursHi: assert property (p_hoursHi) else $error("hours high word wrong");

    property p_flagsC;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_FLAGS_C
            |=> rspData_q[15:2] == 14'h0000 && rspData_q[1:0] == $past(snap_q.shutdownCauseC);
    endproperty
    a_flagsC: assert property (p_flagsC) else $error("third shutdown word wrong");

    property p_fresh;
        clkEn ##1 clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_VOLTAGE
            |=> rspData_q == $past(meas.voltTenths, 2);
    endproperty
    a_fresh: assert property (p_fresh) else $error("voltage not latest");

    property p_freeze;
        !clkEn |=> $stable(ctrl_q) && $stable(rspValid_q) && $stable(snap_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_faultData;
        rspValid_q && rspFault_q |-> rspData_q == ecs_pkg::WORD_ZERO;
    endproperty
    a_faultData: assert property (p_faultData) else $error("refused access returned data");

    property p_answer;
        clkEn && forUs |=> rspValid_q;
    endproperty
    a_answer: assert property (p_answer) else $error("own node access not answered");

    property p_localLoad;
        clkEn && localLoad && !(forUs && req.write && isRw) |=> ctrl_q == $past(localCtrl);
    endproperty
    a_localLoad: assert property (p_localLoad) else $error("local settings not reloaded");

    property p_saveCopy;
        clkEn && saveReq |=> saveStrobe_q && savedCtrl_q == $past(ctrl_q);
    endproperty
    a_saveCopy: assert property (p_saveCopy) else $error("save did not hand over settings");

    property p_hoursLo;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_HOURS_LO
            |=> rspData_q == $past(snap_q.hours[15:0]);
    endproperty
    a_hoursLo: assert property (p_hoursLo) else $error("hours low word wrong");

    property p_stateCode;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_STATE
            |=> rspData_q[15:5] == 11'h000 && rspData_q[4:0] == $past(snap_q.seqState);
    endproperty
    a_stateCode: assert property (p_stateCode) else $error("sequencer code wrong");

    property p_flagsA;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_FLAGS_A
            |=> rspData_q == $past(snap_q.shutdownCauseA);
    endproperty
    a_flagsA: assert property (p_flagsA) else $error("first shutdown word wrong");

    property p_flagsB;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_FLAGS_B
            |=> rspData_q == $past(snap_q.shutdownCauseB);
    endproperty
    a_flagsB: assert property (p_flagsB) else $error("second shutdown word wrong");

    property p_manualOnly;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_MANUAL_ONLY
            |=> rspData_q[15:1] == 15'h0000 && rspData_q[0] == $past(snap_q.manualOnly);
    endproperty
    a_manualOnly: assert property (p_manualOnly) else $error("manual-only flag wrong");

    property p_loadedSpeed;
        clkEn && forUs && !req.write && req.addr == ecs_pkg::REG_LOADED_SPEED
            |=> rspData_q == $past(snap_q.loadedSpeed);
    endproperty
    a_loadedSpeed: assert property (p_loadedSpeed) else $error("loaded speed wrong");

    c_read: cover property (clkEn && forUs && !req.write && mapped ##1 rspValid_q);
    c_start: cover property (clkEn && forUs && req.write && req.addr == ecs_pkg::REG_RUN_CMD && req.data[0]);
    c_fault: cover property (rspValid_q && rspFault_q);
    c_save: cover property (saveStrobe_q);
    c_frozen: cover property (!clkEn && forUs);

endmodule : ecs_regs

// file: verif/ecs_master.sv
// Remote serial master model: issues one register access at a time to the bank.
// Assumes the bank registers its answer on the edge that takes the access; it is sampled on the next falling edge.
`timescale 1ns/1ps
module ecs_master (
    input wire logic clk, // System clock
    output ecs_pkg::ecs_req_t req, // Access towards the bank
    input wire logic rspValid, // Answer strobe
    input wire logic [15:0] rspData, // Answer data
    input wire logic rspFault // Answer exception
);
    // Idle until the first access
    initial req = '0;

    // One access held for one taking edge, then released with scrambled lines
    task automatic xfer(input logic wr, input logic [7:0] node, input logic [15:0] addr,
                        input logic [15:0] data, output logic got, output logic [15:0] rd, output logic flt);
        @(posedge clk);
        req <= {1'b1, wr, node, addr, data};
        @(posedge clk);
        req <= {1'b0, ~wr, ~node, ~addr, ~data};
        @(negedge clk);
        got = rspValid;
        rd = rspData;
        flt = rspFault;
    endtask : xfer
endmodule : ecs_master

// file: verif/engine_controller_status_regs_tb.sv
// Self-checking bench for the engine controller register bank.
// Assumes the master model drives all accesses; clock enable stays high except during the freeze test.
`timescale 1ns/1ps
module engine_controller_status_regs_tb;
    localparam logic [7:0] NODE = ecs_pkg::NODE_DEFAULT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ecs_pkg::ecs_req_t req;
    ecs_pkg::ecs_meas_t meas = '0;
    ecs_pkg::ecs_ctrl_t localCtrl = {1'b1, 1'b0, 16'h0960};
    logic localLoad = 1'b0;
    logic saveReq = 1'b0;
    logic clkEn = 1'b1;
    logic rspValid_q, rspFault_q, saveStrobe_q;
    logic [15:0] rspData_q;
    ecs_pkg::ecs_ctrl_t ctrl_q, savedCtrl_q;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    logic got, flt;
    logic [15:0] rd;

    // Clock, 100 ns period
    always #50 clk = ~clk;

    ecs_master master (.clk(clk), .req(req), .rspValid(rspValid_q), .rspData(rspData_q), .rspFault(rspFault_q));

    ecs_regs DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .req(req), .meas(meas), .localCtrl(localCtrl),
        .localLoad(localLoad), .saveReq(saveReq), .rspValid_q(rspValid_q), .rspData_q(rspData_q),
        .rspFault_q(rspFault_q), .ctrl_q(ctrl_q), .saveStrobe_q(saveStrobe_q), .savedCtrl_q(savedCtrl_q));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // Read one register and judge answer, exception and data
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
        master.xfer(1'b0, NODE, a, 16'h0000, got, rd, flt);
        check({what, " answer"}, 32'({got, flt}), 32'h2);
        check(what, 32'(rd), 32'(exp));
    endtask : rd_chk

    // Expected status word worked out from the live measurements
    function automatic logic [15:0] status_word(input logic [15:0] a);
        case (a)
            ecs_pkg::REG_HOURS_HI: return meas.hours[31:16];
            ecs_pkg::REG_HOURS_LO: return meas.hours[15:0];
            ecs_pkg::REG_SPEED: return meas.speed;
            ecs_pkg::REG_VOLTAGE: return meas.voltTenths;
            ecs_pkg::REG_OIL: return meas.oil;
            ecs_pkg::REG_TEMP: return meas.temp;
            ecs_pkg::REG_STATE: return {11'h000, meas.seqState};
            ecs_pkg::REG_FLAGS_A: return meas.shutdownCauseA;
            ecs_pkg::REG_FLAGS_B: return meas.shutdownCauseB;
            ecs_pkg::REG_FLAGS_C: return {14'h0000, meas.shutdownCauseC};
            ecs_pkg::REG_LEVEL: return meas.level;
            ecs_pkg::REG_AMBIENT: return meas.ambient;
            ecs_pkg::REG_LOADED_SPEED: return meas.loadedSpeed;
            default: return {15'h0000, meas.manualOnly};
        endcase
    endfunction : status_word

    task automatic t_status;
        @(posedge clk) meas <= {32'h0001_2345, 16'h0708, 16'h007d, 16'h0190, 16'h0052, 16'h0011, 16'h0019,
            16'h06a4, 1'b1, ecs_pkg::SEQ_RUN_LOADED, 16'ha5c3, 16'h8001, 2'b10};
        repeat (2) @(posedge clk);
        for (int a = 16'h9c41; a <= 16'h9c51; a++) begin
            if (a != 16'h9c4c && a != 16'h9c4d && a != 16'h9c4f) begin
                rd_chk("status word", 16'(a), status_word(16'(a)));
            end
        end
        for (int s = 0; s <= 16; s++) begin
            @(posedge clk) meas.seqState <= ecs_pkg::ecs_seq_t'(s[4:0]);
            repeat (2) @(posedge clk);
            rd_chk("sequencer code", ecs_pkg::REG_STATE, 16'(s));
        end
        $display("test status done");
    endtask : t_status

    task automatic t_write;
        logic [15:0] wa [5] = '{ecs_pkg::REG_RUN_CMD, ecs_pkg::REG_RUN_CMD, ecs_pkg::REG_MODE, ecs_pkg::REG_MODE,
            ecs_pkg::REG_SPEED_CEIL};
        logic [15:0] wd [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0abc};
        ecs_pkg::ecs_ctrl_t e;
        e = localCtrl;
        for (int i = 0; i < 5; i++) begin
            master.xfer(1'b1, NODE, wa[i], wd[i], got, rd, flt);
            if (wa[i] == ecs_pkg::REG_RUN_CMD) e.runStart = wd[i][0];
            else if (wa[i] == ecs_pkg::REG_MODE) e.modeAuto = wd[i][0];
            else e.speedCeil = wd[i];
            check("write answer", 32'({got, flt, rd}), {14'h0000, 2'b10, wd[i]});
            check("settings in force", 32'(ctrl_q), 32'(e));
            rd_chk("read back", wa[i], wd[i]);
        end
        $display("test write done");
    endtask : t_write

    task automatic t_refuse;
        ecs_pkg::ecs_ctrl_t e;
        e = {1'b1, 1'b0, 16'h0abc};
        master.xfer(1'b1, NODE, ecs_pkg::REG_SPEED, 16'hffff, got, rd, flt);
        check("read-only write", 32'({got, flt, rd}), 32'h30000);
        rd_chk("read-only kept", ecs_pkg::REG_SPEED, meas.speed);
        master.xfer(1'b1, NODE, 16'h9c52, 16'h0001, got, rd, flt);
        check("unmapped write", 32'({got, flt, rd}), 32'h30000);
        master.xfer(1'b1, 8'h02, ecs_pkg::REG_RUN_CMD, 16'h0000, got, rd, flt);
        check("foreign node answer", 32'(got), 32'h0);
        check("foreign node write", 32'(ctrl_q), 32'(e));
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_save;
        @(posedge clk) saveReq <= 1'b1;
        @(posedge clk) saveReq <= 1'b0;
        @(negedge clk);
        check("save strobe", 32'({saveStrobe_q, savedCtrl_q}), {13'h0000, 1'b1, 1'b1, 1'b0, 16'h0abc});
        @(negedge clk);
        check("save strobe end", 32'(saveStrobe_q), 32'h0);
        @(posedge clk) localLoad <= 1'b1;
        @(posedge clk) localLoad <= 1'b0;
        @(negedge clk);
        check("local reload", 32'(ctrl_q), 32'(localCtrl));
        master.xfer(1'b1, NODE, ecs_pkg::REG_MODE, 16'h0001, got, rd, flt);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        @(negedge clk);
        check("power cycle restore", 32'({rspValid_q, ctrl_q}), 32'(localCtrl));
        $display("test save done");
    endtask : t_save

    // Access while the clock enable is low must be neither answered nor applied
    task automatic t_freeze;
        @(posedge clk) clkEn <= 1'b0;
        master.xfer(1'b1, NODE, ecs_pkg::REG_SPEED_CEIL, 16'h0123, got, rd, flt);
        check("frozen answer", 32'(got), 32'h0);
        check("frozen settings", 32'(ctrl_q), 32'(localCtrl));
        @(posedge clk) clkEn <= 1'b1;
        rd_chk("thawed read", ecs_pkg::REG_SPEED_CEIL, localCtrl.speedCeil);
        $display("test freeze done");
    endtask : t_freeze

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset state", 32'({rspValid_q, saveStrobe_q, ctrl_q}), 32'(localCtrl));
        t_status();
        t_write();
        t_refuse();
        t_save();
        t_freeze();
        finish_test();
    end
endmodule : engine_controller_status_regs_tb
